// file: hw/nbpc_map.svh
// Constants of the NAND block-protect and command-frame front end.
// Assumes inclusion by the package and the design modules only.
`ifndef NBPC_MAP_SVH
`define NBPC_MAP_SVH

// ----------------------------------------------------------------
// Array geometry
// ----------------------------------------------------------------
`define NBPC_PAGE_W        16
`define NBPC_BLOCK_SHIFT   6
`define NBPC_PAGE_FIRST    16'h0000
`define NBPC_PAGE_LAST     16'hFFFF
`define NBPC_BLOCK_MASK    16'h003F
`define NBPC_LEVEL_SHIFT0  4'hA

// ----------------------------------------------------------------
// Operation codes
// ----------------------------------------------------------------
`define NBPC_OP_RESET      8'hFF
`define NBPC_OP_ID         8'h9F
`define NBPC_OP_RDSR_A     8'h0F
`define NBPC_OP_RDSR_B     8'h05
`define NBPC_OP_WRSR_A     8'h1F
`define NBPC_OP_WRSR_B     8'h01
`define NBPC_OP_WREN       8'h06
`define NBPC_OP_WRDI       8'h04
`define NBPC_OP_REMAP      8'hA1
`define NBPC_OP_RDLUT      8'hA5
`define NBPC_OP_ECCPA      8'hA9
`define NBPC_OP_ERASE      8'hD8
`define NBPC_OP_LOAD       8'h02
`define NBPC_OP_RLOAD      8'h84
`define NBPC_OP_QLOAD      8'h32
`define NBPC_OP_RQLOAD     8'h34
`define NBPC_OP_PROGRAM    8'h10
`define NBPC_OP_PAGE_READ  8'h13

// ----------------------------------------------------------------
// Frame lengths in bytes, opcode included; page address byte positions
// ----------------------------------------------------------------
`define NBPC_LEN_PAGE_CMD  4'h4
`define NBPC_LEN_REMAP     4'h5
`define NBPC_LEN_SHORT     4'h1
`define NBPC_BYTE_PA_HI    4'h2
`define NBPC_BYTE_PA_LO    4'h3

// ----------------------------------------------------------------
// Status byte layout
// ----------------------------------------------------------------
`define NBPC_SR_BUSY       0
`define NBPC_SR_EFAIL      2
`define NBPC_SR_PFAIL      3

// ----------------------------------------------------------------
// Pin sampler reset levels {cs_n, clk, di}
// ----------------------------------------------------------------
`define NBPC_PIN_IDLE      3'h4

`endif

// file: hw/nbpc_pin_sync.sv
// Three-stage sampler for pins from outside the system clock.
// Assumes asynchronous inputs; output moves when stages 2 and 3 agree.
`timescale 1ns/1ps
`include "nbpc_map.svh"

module nbpc_pin_sync #(
    parameter int             W       = 3,
    parameter logic [W-1:0]   RST_VAL = '0
) (
    // Clock and reset
    input  wire logic         i_clk_sys,
    input  wire logic         i_rst,
    // Pins and filtered levels
    input  wire logic [W-1:0] i_pins,
    output logic      [W-1:0] o_level
);

    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    if (W < 1) begin : g_chk
        $error("nbpc_pin_sync: W must be at least 1");
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            s1_r <= RST_VAL;
            s2_r <= RST_VAL;
            s3_r <= RST_VAL;
        end else begin
            s1_r <= i_pins;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // Glitch shorter than one sample never reaches the parser
    for (genvar g = 0; g < W; g++) begin : g_filt
        always_ff @(posedge i_clk_sys or posedge i_rst) begin
            if (i_rst) begin
                o_level[g] <= RST_VAL[g];
            end else if (s2_r[g] == s3_r[g]) begin
                o_level[g] <= s3_r[g];
            end
        end
    end

endmodule

// file: hw/nbpc_pkg.sv
// Types shared by the front end modules.
// Assumes nbpc_map.svh is on the include path.
`include "nbpc_map.svh"

package nbpc_pkg;

    // ------------------------------------------------------------
    // Array operations handed to the array engine
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        NBPC_K_PROGRAM,
        NBPC_K_ERASE,
        NBPC_K_PAGE_READ,
        NBPC_K_REMAP
    } nbpc_kind_t;

    typedef struct packed {
        nbpc_kind_t                    kind;
        logic [`NBPC_PAGE_W-1:0]       page;
    } nbpc_op_t;

    // ------------------------------------------------------------
    // Protected page range
    // ------------------------------------------------------------
    typedef struct packed {
        logic                          none;
        logic [`NBPC_PAGE_W-1:0]       lo;
        logic [`NBPC_PAGE_W-1:0]       hi;
    } nbpc_range_t;

endpackage

// file: hw/nbpc_prot_dec.sv
// Block-protect level decoder into a protected page range.
// Assumes static level and top/bottom inputs from the status logic.
`timescale 1ns/1ps
`include "nbpc_map.svh"

module nbpc_prot_dec (
    // Protect setting
    input  wire logic              i_top_bottom_select,
    input  wire logic [3:0]        i_level,
    // Decoded range
    output nbpc_pkg::nbpc_range_t  o_range
);

    logic [`NBPC_PAGE_W-1:0] span;

    always_comb begin
        span          = `NBPC_PAGE_LAST >> (`NBPC_LEVEL_SHIFT0 - i_level);
        o_range.none  = 1'b0;
        o_range.lo    = `NBPC_PAGE_FIRST;
        o_range.hi    = `NBPC_PAGE_LAST;
        // (R2) zero level
        if (i_level == 4'h0) begin
            o_range.none = 1'b1;
        // (R2) whole array
        end else if (i_level[3:2] == 2'b11 || i_level[3:1] == 3'b101) begin
            o_range.lo = `NBPC_PAGE_FIRST;
            o_range.hi = `NBPC_PAGE_LAST;
        // (R1) top range
        end else if (!i_top_bottom_select) begin
            o_range.lo = ~span;
            o_range.hi = `NBPC_PAGE_LAST;
        // (R1) bottom range
        end else begin
            o_range.lo = `NBPC_PAGE_FIRST;
            o_range.hi = span;
        end
    end

endmodule

// file: hw/nbpc_top.sv
// Serial NAND front end: protect decode, command framing, busy gating.
// Assumes an array engine that pulses i_op_done when an operation ends.
//
// Functional notes
// (R1) Levels 1 to 9 protect 2^n blocks at top or bottom per select.
// (R2) Level zero protects nothing; 1010, 1011, 11xx protect the whole array.
// (R3) Program or erase overlapping the protected range is dropped.
// (R4) Chip select falling starts a frame and resets the parser.
// (R5) First byte of the frame is the opcode.
// (R6) Input sampled on clock rise, most significant bit first.
// (R7) Opcode may be followed by address, data or dummy bytes.
// (R8) Chip select rising completes the instruction.
// (R9) Reads may end after any bit count.
// (R10) Write, program, erase ending off a byte boundary is discarded.
// (R11) Busy high during program, erase, remap and page load; the code sets it for page read instead, not for the load opcodes.
// (R12) While busy only status read and identification read are served.
// (R13) Decoder recognises the basic instruction set.
// (R14) Identification returns 8-bit maker code then 16-bit part code.
// (R15) Protected program or erase sets its fail flag; next one clears.
// (R16) Busy clears when the internal operation completes.
`timescale 1ns/1ps
`include "nbpc_map.svh"

module nbpc_top #(
    parameter logic [7:0]  MAKER_CODE = 8'h5A,    // Arbitrary value
    parameter logic [15:0] PART_CODE  = 16'h1234  // Arbitrary value
) (
    // Clock and reset
    input  wire logic              i_clk_sys,
    input  wire logic              i_rst,
    // Serial link pins
    input  wire logic              i_spi_cs_n,
    input  wire logic              i_spi_clk,
    input  wire logic              i_spi_di,
    output logic                   o_spi_do,
    output logic                   o_spi_do_oe,
    // Protect setting
    input  wire logic              i_top_bottom_select,
    input  wire logic [3:0]        i_protect_level,
    // Array engine
    output logic                   o_op_start,
    output nbpc_pkg::nbpc_op_t     o_op,
    input  wire logic              i_op_done,
    // Status
    output logic                   o_busy,
    output logic                   o_program_fail,
    output logic                   o_erase_fail
);

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    // (R13) known opcodes
    function automatic logic is_known(input logic [7:0] op);
        case (op)
            8'hFF, 8'h9F, 8'h0F, 8'h05, 8'h1F, 8'h01, 8'h06, 8'h04,
            8'hA1, 8'hA5, 8'hA9, 8'hD8, 8'h02, 8'h84, 8'h32, 8'h34,
            8'h10, 8'h13, 8'h03, 8'h0B, 8'h0C, 8'h3B, 8'h3C, 8'h6B,
            8'h6C, 8'hBB, 8'hBC, 8'hEB, 8'hEC: is_known = 1'b1;
            default:                           is_known = 1'b0;
        endcase
    endfunction

    function automatic logic is_status(input logic [7:0] op);
        is_status = (op == `NBPC_OP_RDSR_A) || (op == `NBPC_OP_RDSR_B);
    endfunction

    function automatic logic is_modify(input logic [7:0] op);
        case (op)
            8'h1F, 8'h01, 8'h06, 8'h04, 8'hA1, 8'hD8,
            8'h02, 8'h84, 8'h32, 8'h34, 8'h10, 8'hFF: is_modify = 1'b1;
            default:                               is_modify = 1'b0;
        endcase
    endfunction

    function automatic logic [3:0] need_len(input logic [7:0] op);
        case (op)
            `NBPC_OP_PROGRAM, `NBPC_OP_ERASE,
            `NBPC_OP_PAGE_READ: need_len = `NBPC_LEN_PAGE_CMD;
            `NBPC_OP_REMAP:     need_len = `NBPC_LEN_REMAP;
            default:            need_len = `NBPC_LEN_SHORT;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Pin sampling and edges
    // ------------------------------------------------------------
    logic [2:0]              pins_f;
    logic                    cs_f;
    logic                    sck_f;
    logic                    di_f;
    logic                    cs_q_r;
    logic                    sck_q_r;
    logic                    cs_fall;
    logic                    cs_rise;
    logic                    sck_rise;
    logic                    sck_fall;

    nbpc_pin_sync #(
        .W       (3),
        .RST_VAL (`NBPC_PIN_IDLE)
    ) u_sync (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_pins    ({i_spi_cs_n, i_spi_clk, i_spi_di}),
        .o_level   (pins_f)
    );

    assign cs_f  = pins_f[2];
    assign sck_f = pins_f[1];
    assign di_f  = pins_f[0];

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            cs_q_r  <= 1'b1;
            sck_q_r <= 1'b0;
        end else begin
            cs_q_r  <= cs_f;
            sck_q_r <= sck_f;
        end
    end

    assign cs_fall  = cs_q_r & ~cs_f;
    assign cs_rise  = ~cs_q_r & cs_f;
    // (R6) rising edge samples input
    assign sck_rise = ~sck_q_r & sck_f & ~cs_f;
    assign sck_fall = sck_q_r & ~sck_f & ~cs_f;

    // ------------------------------------------------------------
    // Frame parser
    // ------------------------------------------------------------
    logic [2:0]              bit_cnt_r;
    logic [3:0]              byte_cnt_r;
    logic [7:0]              sh_r;
    logic [7:0]              opcode_r;
    logic                    ignore_r;
    logic [15:0]             page_r;
    logic                    byte_done;
    logic [7:0]              rx_byte;

    assign byte_done = sck_rise && (bit_cnt_r == 3'h7);
    // (R6) most significant bit first
    assign rx_byte   = {sh_r[6:0], di_f};

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            bit_cnt_r  <= 3'h0;
            byte_cnt_r <= 4'h0;
            sh_r       <= 8'h00;
        // (R4) parser restart
        end else if (cs_fall) begin
            bit_cnt_r  <= 3'h0;
            byte_cnt_r <= 4'h0;
        end else if (sck_rise) begin
            sh_r      <= rx_byte;
            bit_cnt_r <= bit_cnt_r + 3'h1;
            // Saturates: long data phases only need "at least" lengths
            if (byte_done && byte_cnt_r != 4'hF) begin
                byte_cnt_r <= byte_cnt_r + 4'h1;
            end
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            opcode_r <= 8'h00;
            ignore_r <= 1'b0;
        end else if (cs_fall) begin
            opcode_r <= 8'h00;
            ignore_r <= 1'b0;
        // (R5) first byte is opcode
        end else if (byte_done && byte_cnt_r == 4'h0) begin
            opcode_r <= rx_byte;
            // (R12) busy gating
            ignore_r <= !is_known(rx_byte) ||
                        (o_busy && !is_status(rx_byte) &&
                         rx_byte != `NBPC_OP_ID);
        end
    end

    // (R7) address bytes after a dummy byte
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            page_r <= 16'h0000;
        end else if (byte_done && byte_cnt_r == `NBPC_BYTE_PA_HI) begin
            page_r[15:8] <= rx_byte;
        end else if (byte_done && byte_cnt_r == `NBPC_BYTE_PA_LO) begin
            page_r[7:0] <= rx_byte;
        end
    end

    // ------------------------------------------------------------
    // Completion and protection
    // ------------------------------------------------------------
    nbpc_pkg::nbpc_range_t   range;
    logic                    ends_ok;
    logic                    act;
    logic                    is_pe;
    logic                    hit;
    logic                    rejected;
    logic                    start;
    logic [15:0]             tgt_lo;
    logic [15:0]             tgt_hi;
    nbpc_pkg::nbpc_kind_t    kind;

    nbpc_prot_dec u_prot (
        .i_top_bottom_select (i_top_bottom_select),
        .i_level             (i_protect_level),
        .o_range             (range)
    );

    // (R9) reads end anywhere; (R10) modifying ones on a byte boundary
    assign ends_ok = is_modify(opcode_r) ? (bit_cnt_r == 3'h0) : 1'b1;
    // (R8) completion on chip select rise
    assign act     = cs_rise && !ignore_r && (byte_cnt_r != 4'h0) &&
                     ends_ok && (byte_cnt_r >= need_len(opcode_r));
    assign is_pe   = (opcode_r == `NBPC_OP_PROGRAM) ||
                     (opcode_r == `NBPC_OP_ERASE);
    // An erase covers its whole block, a program one page
    assign tgt_lo  = (opcode_r == `NBPC_OP_ERASE) ?
                     (page_r & ~`NBPC_BLOCK_MASK) : page_r;
    assign tgt_hi  = (opcode_r == `NBPC_OP_ERASE) ?
                     (page_r | `NBPC_BLOCK_MASK) : page_r;
    // (R3) overlap test
    assign hit      = !range.none && tgt_lo <= range.hi &&
                      tgt_hi >= range.lo;
    assign rejected = act && is_pe && hit;

    always_comb begin
        unique case (opcode_r)
            `NBPC_OP_PROGRAM: kind = nbpc_pkg::NBPC_K_PROGRAM;
            `NBPC_OP_ERASE:   kind = nbpc_pkg::NBPC_K_ERASE;
            `NBPC_OP_REMAP:   kind = nbpc_pkg::NBPC_K_REMAP;
            default:          kind = nbpc_pkg::NBPC_K_PAGE_READ;
        endcase
    end

    // (R3) protected requests never reach the array
    assign start = act && !rejected &&
                   (is_pe || opcode_r == `NBPC_OP_PAGE_READ ||
                    opcode_r == `NBPC_OP_REMAP);

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_op_start <= 1'b0;
            o_op       <= '{kind: nbpc_pkg::NBPC_K_PROGRAM, page: 16'h0000};
        end else begin
            o_op_start <= start;
            if (start) begin
                o_op.kind <= kind;
                o_op.page <= page_r;
            end
        end
    end

    // ------------------------------------------------------------
    // Busy and fail flags
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_busy <= 1'b0;
        // (R11) busy while the array works
        end else if (start) begin
            o_busy <= 1'b1;
        // (R16) completion clears busy
        end else if (i_op_done) begin
            o_busy <= 1'b0;
        end
    end

    // (R15) set wins over the clearing command
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_program_fail <= 1'b0;
            o_erase_fail   <= 1'b0;
        end else if (act && (is_pe || opcode_r == `NBPC_OP_RESET)) begin
            o_program_fail <= rejected && opcode_r == `NBPC_OP_PROGRAM;
            o_erase_fail   <= rejected && opcode_r == `NBPC_OP_ERASE;
        end
    end

    // ------------------------------------------------------------
    // Serial output: identification and status
    // ------------------------------------------------------------
    logic [23:0]             tx_r;
    logic                    tx_act_r;
    logic [7:0]              status;

    always_comb begin
        status                = 8'h00;
        status[`NBPC_SR_BUSY]  = o_busy;
        status[`NBPC_SR_EFAIL] = o_erase_fail;
        status[`NBPC_SR_PFAIL] = o_program_fail;
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            tx_r     <= 24'h00_0000;
            tx_act_r <= 1'b0;
            o_spi_do <= 1'b0;
        end else if (cs_fall || cs_rise) begin
            tx_act_r <= 1'b0;
        end else if (byte_done && byte_cnt_r >= 4'h1) begin
            // (R14) maker code then part code after one dummy byte
            if (opcode_r == `NBPC_OP_ID && byte_cnt_r == 4'h1) begin
                tx_r     <= {MAKER_CODE, PART_CODE};
                tx_act_r <= 1'b1;
            end else if (is_status(opcode_r)) begin
                tx_r[23:16] <= status;
                tx_act_r    <= 1'b1;
            end
        end else if (sck_fall && tx_act_r) begin
            o_spi_do <= tx_r[23];
            tx_r     <= {tx_r[22:0], 1'b0};
        end
    end

    assign o_spi_do_oe = tx_act_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    AST_LEVEL_ZERO: assert property ( // (R2)
        i_protect_level == 4'h0 |-> range.none)
        else $error("level zero must protect nothing");
    AST_LEVEL_ALL: assert property ( // (R2)
        i_protect_level[3:2] == 2'b11 |->
        !range.none && range.lo == 16'h0000 && range.hi == 16'hFFFF)
        else $error("upper levels must protect all pages");
    AST_TOP_RANGE: assert property ( // (R1)
        i_protect_level == 4'h1 && !i_top_bottom_select |->
        range.lo == 16'hFF80 && range.hi == 16'hFFFF)
        else $error("top range for level one wrong");
    AST_BOTTOM_RANGE: assert property ( // (R1)
        i_protect_level == 4'h9 && i_top_bottom_select |->
        range.lo == 16'h0000 && range.hi == 16'h7FFF)
        else $error("bottom range for level nine wrong");
    AST_PROT_DROP: assert property ( // (R3)
        rejected |=> !o_op_start ##1 !o_busy || $past(o_busy))
        else $error("protected request reached the array");
    AST_CS_RESTART: assert property ( // (R4)
        cs_fall |=> bit_cnt_r == 3'h0 && byte_cnt_r == 4'h0)
        else $error("parser not reset at frame start");
    AST_UNALIGNED: assert property ( // (R10)
        cs_rise && bit_cnt_r != 3'h0 && is_modify(opcode_r) |=>
        !o_op_start && $stable(o_program_fail))
        else $error("unaligned modifying frame acted on");
    AST_BUSY_HOLD: assert property ( // (R11)
        o_op_start |-> o_busy until_with i_op_done)
        else $error("busy dropped before completion");
    AST_BUSY_END: assert property ( // (R16)
        o_busy && i_op_done |=> !o_busy)
        else $error("busy not cleared on completion");
    AST_BUSY_GATE: assert property ( // (R12)
        o_busy && !i_op_done |=> !o_op_start)
        else $error("operation started while busy");
    AST_FAIL_SET: assert property ( // (R15)
        rejected |=> o_program_fail || o_erase_fail)
        else $error("fail flag not set on protected request");

    COV_PROGRAM: cover property (
        o_op_start && o_op.kind == nbpc_pkg::NBPC_K_PROGRAM);
    COV_REJECT: cover property (rejected);
    COV_ID_OUT: cover property (
        tx_act_r && opcode_r == `NBPC_OP_ID ##[1:300] cs_rise);
    COV_BUSY_DONE: cover property (o_busy ##1 !o_busy);

endmodule

// file: test/nbpc_spi_host.sv
// Host model for the serial link: mode 0, single lane, one frame per call.
// Assumes the bench calls frame() and waits until it returns.
`timescale 1ns/1ps

module nbpc_spi_host (
    // Link pins
    output logic      o_cs_n,
    output logic      o_clk,
    output logic      o_di,
    input  wire logic i_do
);
    // ------------------------------------------------------------
    // Framing
    // ------------------------------------------------------------
    initial begin
        o_cs_n = 1'h1;
        o_clk  = 1'h0;
        o_di   = 1'h0;
    end

    task automatic frame(input logic [63:0] d, input int n,
                         output logic [63:0] rx);
        rx = '0;
        o_cs_n <= 1'h0;
        for (int i = 63; i > 63 - n; i--) begin
            o_di <= d[i];
            #32;
            rx = {rx[62:0], i_do};
            o_clk <= 1'h1;
            #32;
            o_clk <= 1'h0;
        end
        #32;
        o_cs_n <= 1'h1;
        // Released line shows the inverse so stale data never looks valid
        o_di <= ~o_di;
        #64;
    endtask
endmodule

// file: test/nbpc_top_tb.sv
// Bench for the front end: protect decode, framing and busy gating.
// Assumes the host model drives the link; the engine is i_op_done.
`timescale 1ns/1ps

module nbpc_top_tb;
    localparam logic [7:0]  MAKER = 8'h5A;    // Arbitrary value
    localparam logic [15:0] PART  = 16'h1234; // Arbitrary value
    typedef struct packed {
        logic [7:0]  opc;
        logic        tbs;
        logic [3:0]  lvl;
        logic [15:0] page;
        logic        start;
        logic        pf;
        logic        ef;
    } nbpc_row_t;
    logic               clk_sys, rst, cs_n, sclk, di, sdo, sdo_oe;
    logic               tbs, op_start, op_done, busy, pfail, efail;
    logic [3:0]         level;
    logic [63:0]        rx;
    nbpc_pkg::nbpc_op_t op, last_op;
    int                 n_errors, n_tests, n_starts, s0;
    // Accepted programs and erase sit between rejects so flags restart; the page read leaves them
    nbpc_row_t rows [11] = '{
        '{8'h10, 1'h0, 4'h1, 16'hFF80, 1'h0, 1'h1, 1'h0},
        '{8'h10, 1'h0, 4'h1, 16'hFF7F, 1'h1, 1'h0, 1'h0},
        '{8'h10, 1'h1, 4'h9, 16'h7FFF, 1'h0, 1'h1, 1'h0},
        '{8'h10, 1'h1, 4'h9, 16'h8000, 1'h1, 1'h0, 1'h0},
        '{8'h10, 1'h1, 4'h0, 16'hFFFF, 1'h1, 1'h0, 1'h0},
        '{8'h10, 1'h1, 4'hA, 16'hFFFF, 1'h0, 1'h1, 1'h0},
        '{8'hD8, 1'h0, 4'h1, 16'hFF7F, 1'h1, 1'h0, 1'h0},
        '{8'h13, 1'h1, 4'hF, 16'h1234, 1'h1, 1'h0, 1'h0},
        '{8'hD8, 1'h0, 4'hB, 16'h0000, 1'h0, 1'h0, 1'h1},
        '{8'hD8, 1'h1, 4'hC, 16'h8000, 1'h0, 1'h0, 1'h1},
        '{8'hD8, 1'h1, 4'h1, 16'h0040, 1'h0, 1'h0, 1'h1}};

    nbpc_top #(.MAKER_CODE(MAKER), .PART_CODE(PART)) i_dut (
        .i_clk_sys(clk_sys), .i_rst(rst), .i_spi_cs_n(cs_n),
        .i_spi_clk(sclk), .i_spi_di(di), .o_spi_do(sdo),
        .o_spi_do_oe(sdo_oe), .i_top_bottom_select(tbs),
        .i_protect_level(level), .o_op_start(op_start), .o_op(op),
        .i_op_done(op_done), .o_busy(busy), .o_program_fail(pfail),
        .o_erase_fail(efail));
    // Undriven data line reads inverted so a missing enable shows up
    nbpc_spi_host i_host (.o_cs_n(cs_n), .o_clk(sclk), .o_di(di),
        .i_do(sdo_oe ? sdo : ~sdo));

    // ------------------------------------------------------------
    // Checks and helpers
    // ------------------------------------------------------------
    task automatic chk_bit(input string nm, input logic e, input logic g);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic chk_vec(input string nm, input logic [31:0] e,
                           input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic send(input logic [7:0] opc, input logic [15:0] pg,
                        input int n);
        s0 = n_starts;
        i_host.frame({opc, 8'h00, pg, 32'h0000_0000}, n, rx);
        repeat (2) @(posedge clk_sys);
    endtask
    task automatic finish_op();
        @(posedge clk_sys);
        op_done <= 1'h1;
        @(posedge clk_sys);
        op_done <= 1'h0;
        repeat (2) @(posedge clk_sys);
        chk_bit("busy", 1'h0, busy);
    endtask
    task automatic summarize();
        if (n_errors == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    function automatic logic [1:0] kind_of(input logic [7:0] o);
        return (o == 8'hD8) ? 2'h1 : ((o == 8'h13) ? 2'h2 : 2'h0);
    endfunction

    always @(posedge clk_sys) begin
        if (op_start === 1'h1) begin
            n_starts++;
            last_op = op;
        end
    end
    initial begin
        clk_sys = 1'h0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    // Whole run needs about 49 us of link traffic
    initial begin
        #200000;
        n_errors++;
        summarize();
    end

    initial begin
        rst = 1'h1;
        tbs = 1'h0;
        level = 4'h0;
        op_done = 1'h0;
        repeat (3) @(posedge clk_sys);
        rst <= 1'h0;
        repeat (8) @(posedge clk_sys);
        chk_bit("pfail", 1'h0, pfail);
        chk_bit("busy", 1'h0, busy);
        foreach (rows[k]) begin
            tbs <= rows[k].tbs;
            level <= rows[k].lvl;
            send(rows[k].opc, rows[k].page, 32);
            chk_vec("starts", s0 + rows[k].start, n_starts);
            chk_bit("pfail", rows[k].pf, pfail);
            chk_bit("efail", rows[k].ef, efail);
            chk_bit("busy", rows[k].start, busy);
            if (rows[k].start) begin
                chk_vec("op", {kind_of(rows[k].opc), rows[k].page},
                        32'(last_op));
                finish_op();
            end
        end
        level <= 4'h0;
        // Full length but one bit short of a byte: only alignment refuses
        send(8'h10, 16'h0100, 39);
        chk_vec("starts", s0, n_starts);
        chk_bit("efail", 1'h1, efail);
        send(8'h55, 16'h0100, 32);
        chk_vec("starts", s0, n_starts);
        send(8'h10, 16'h0100, 32);
        chk_bit("busy", 1'h1, busy);
        send(8'hD8, 16'h0200, 32);
        chk_vec("starts", s0, n_starts);
        send(8'h9F, 16'h0000, 40);
        chk_vec("id", {MAKER, PART}, 32'(rx[23:0]));
        send(8'h9F, 16'h0000, 29);
        chk_vec("id_cut", {MAKER, PART} >> 11, 32'(rx[12:0]));
        send(8'h0F, 16'h0000, 24);
        chk_vec("status", 32'h0000_0001, 32'(rx[7:0]));
        finish_op();
        send(8'hD8, 16'h0200, 32);
        chk_vec("starts", s0 + 1, n_starts);
        finish_op();
        send(8'hA1, 16'h0300, 40);
        chk_vec("op", {2'h3, 16'h0300}, 32'(last_op));
        finish_op();
        level <= 4'hA;
        send(8'h10, 16'h0000, 32);
        chk_bit("pfail", 1'h1, pfail);
        send(8'hFF, 16'h0000, 8);
        chk_bit("pfail", 1'h0, pfail);
        send(8'h10, 16'h0000, 32);
        chk_bit("pfail", 1'h1, pfail);
        // Reset in mid-run must drop the fail flag again
        rst <= 1'h1;
        repeat (3) @(posedge clk_sys);
        rst <= 1'h0;
        repeat (8) @(posedge clk_sys);
        chk_bit("pfail", 1'h0, pfail);
        chk_bit("busy", 1'h0, busy);
        summarize();
    end
endmodule
